// ===== core/nvc_pkg.sv
// Constants and types for the nonvolatile SRAM host controller
package nvc_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int CLK_MHZ = 50;
  // Sequence addresses
  localparam logic [12:0] SEQ_A1 = 13'h0000;
  localparam logic [12:0] SEQ_A2 = 13'h1555;
  localparam logic [12:0] SEQ_A3 = 13'h0aaa;
  localparam logic [12:0] SEQ_A4 = 13'h1fff;
  localparam logic [12:0] SEQ_A5 = 13'h10f0;
  localparam logic [12:0] SEQ_SAVE = 13'h0f0f;
  localparam logic [12:0] SEQ_RESTORE = 13'h0f0e;
  localparam logic [12:0] SEQ_TEST = 13'h139c;
  // Bus timing in ns and in clock cycles
  localparam int ACCESS_NS = 45;
  localparam int PULSE_NS = 60;
  localparam int ACCESS_CYC = (ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
  // Nonvolatile operation times
  localparam int SAVE_MS = 10;
  localparam int RESTORE_US = 20;
  localparam int POWERUP_US = 650;
  localparam int SAVE_CYC = SAVE_MS * 1000 * CLK_MHZ;
  localparam int RESTORE_CYC = RESTORE_US * CLK_MHZ;
  localparam int POWERUP_CYC = POWERUP_US * CLK_MHZ;
  localparam int CNT_W = 20;
  // Command codes
  localparam logic [1:0] CMD_READ = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_SAVE = 2'h2;
  localparam logic [1:0] CMD_RESTORE = 2'h3;

  typedef enum logic [2:0] {
    ST_POWERUP = 3'b000,
    ST_IDLE = 3'b001,
    ST_SETUP = 3'b011,
    ST_STROBE = 3'b010,
    ST_GAP = 3'b110,
    ST_BUSY = 3'b111
  } state_t;

  typedef struct packed {
    logic select_n;
    logic write_n;
    logic gate_n;
    logic [12:0] addr;
    logic [7:0] dout;
    logic drive;
  } pins_t;

  typedef struct packed {
    state_t st;
    pins_t pins;
    logic [CNT_W-1:0] cnt;
    logic [2:0] step;
    logic seq;
    logic save;
    logic is_write;
    logic [7:0] rdata;
    logic done;
    logic ready;
  } ctl_t;
endpackage

// ===== core/nvc_host.sv
// Host controller driving the nonvolatile SRAM bus pins
//
// Summary of operation
// - Save needs six reads ending at 0f0f
// - Restore needs same five reads then 0f0e
// - Write strobe held high in sequence
// - Never issue sequence ending in 139c
// - Select strobe clocks every sequence step
// - Address stable across whole write
// - Gate held high during writes
// - Intervening access aborts the sequence
module nvc_host #(
  parameter int SAVE_CYCLES = nvc_pkg::SAVE_CYC,
  parameter int RESTORE_CYCLES = nvc_pkg::RESTORE_CYC,
  parameter int POWERUP_CYCLES = nvc_pkg::POWERUP_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic REQ_VALID,
  input wire logic [1:0] REQ_CMD,
  input wire logic [12:0] REQ_ADDR,
  input wire logic [7:0] REQ_WDATA,
  output logic REQ_READY,
  output logic RSP_VALID,
  output logic [7:0] RSP_RDATA,
  output logic NV_SELECT_N,
  output logic NV_WRITE_N,
  output logic NV_GATE_N,
  output logic [12:0] ADDR_LINES,
  output logic [7:0] DATA_LINES_O,
  output logic DATA_LINES_OE,
  input wire logic [7:0] DATA_LINES_I
);
  initial begin
    if (SAVE_CYCLES < 1 || SAVE_CYCLES >= (1 << nvc_pkg::CNT_W))
      $error("SAVE_CYCLES out of range");
    if (RESTORE_CYCLES < 1 || RESTORE_CYCLES >= (1 << nvc_pkg::CNT_W))
      $error("RESTORE_CYCLES out of range");
    if (POWERUP_CYCLES < 1 || POWERUP_CYCLES >= (1 << nvc_pkg::CNT_W))
      $error("POWERUP_CYCLES out of range");
  end

  localparam logic [19:0] PULSE = 20'(nvc_pkg::PULSE_CYC);
  localparam logic [19:0] ACCESS = 20'(nvc_pkg::ACCESS_CYC);
  localparam logic [19:0] SAVE_T = 20'(SAVE_CYCLES);
  localparam logic [19:0] RESTORE_T = 20'(RESTORE_CYCLES);
  localparam logic [19:0] POWERUP_T = 20'(POWERUP_CYCLES);

  // ----------------------------------------------------------------
  // Sequence address for a step
  // ----------------------------------------------------------------
  function automatic logic [12:0] seq_addr(input logic [2:0] step,
                                            input logic save);
    logic [12:0] a;
    a = nvc_pkg::SEQ_A1;
    case (step)
      3'h0: a = nvc_pkg::SEQ_A1;
      3'h1: a = nvc_pkg::SEQ_A2;
      3'h2: a = nvc_pkg::SEQ_A3;
      3'h3: a = nvc_pkg::SEQ_A4;
      3'h4: a = nvc_pkg::SEQ_A5;
      default: a = save ? nvc_pkg::SEQ_SAVE : nvc_pkg::SEQ_RESTORE;
    endcase
    return a;
  endfunction

  nvc_pkg::ctl_t r;
  nvc_pkg::ctl_t next_r;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    case (r.st)
      nvc_pkg::ST_POWERUP: begin
        // Wait out the automatic restore before any access
        if (r.cnt >= POWERUP_T - 20'h1) begin
          next_r.st = nvc_pkg::ST_IDLE;
          next_r.cnt = '0;
          next_r.ready = 1'b1;
        end else begin
          next_r.cnt = r.cnt + 20'h1;
        end
      end
      nvc_pkg::ST_IDLE: begin
        if (REQ_VALID) begin
          next_r.ready = 1'b0;
          next_r.cnt = '0;
          next_r.st = nvc_pkg::ST_SETUP;
          next_r.pins.gate_n = 1'b1;
          if (REQ_CMD == nvc_pkg::CMD_SAVE ||
              REQ_CMD == nvc_pkg::CMD_RESTORE) begin
            // Whole sequence issued back to back, nothing intervenes
            next_r.seq = 1'b1;
            next_r.save = (REQ_CMD == nvc_pkg::CMD_SAVE);
            next_r.step = 3'h0;
            next_r.is_write = 1'b0;
            // The test sequence ending cannot be produced
            next_r.pins.addr = seq_addr(3'h0, 1'b0);
            next_r.pins.drive = 1'b0;
          end else begin
            next_r.seq = 1'b0;
            next_r.is_write = (REQ_CMD == nvc_pkg::CMD_WRITE);
            next_r.pins.addr = REQ_ADDR;
            next_r.pins.dout = REQ_WDATA;
            next_r.pins.drive = (REQ_CMD == nvc_pkg::CMD_WRITE);
          end
        end
      end
      nvc_pkg::ST_SETUP: begin
        // Address settles one cycle before select falls
        next_r.st = nvc_pkg::ST_STROBE;
        next_r.pins.select_n = 1'b0;
        if (r.is_write) begin
          next_r.pins.write_n = 1'b0;
          next_r.pins.gate_n = 1'b1;
        end else begin
          next_r.pins.write_n = 1'b1;
          next_r.pins.gate_n = 1'b0;
        end
      end
      nvc_pkg::ST_STROBE: begin
        // Address held while strobes are low
        if (r.cnt >= (r.seq ? PULSE : ACCESS) - 20'h1) begin
          next_r.cnt = '0;
          next_r.pins.select_n = 1'b1;
          next_r.pins.write_n = 1'b1;
          next_r.pins.gate_n = 1'b1;
          if (!r.is_write)
            next_r.rdata = DATA_LINES_I;
          next_r.st = nvc_pkg::ST_GAP;
        end else begin
          next_r.cnt = r.cnt + 20'h1;
        end
      end
      nvc_pkg::ST_GAP: begin
        next_r.pins.drive = 1'b0;
        if (r.seq && r.step == 3'h5) begin
          // Data lines float, address and strobes stay driven; wait out the operation
          next_r.st = nvc_pkg::ST_BUSY;
        end else if (r.seq) begin
          // One select pulse per distinct address, never repeated
          next_r.step = r.step + 3'h1;
          next_r.pins.addr = seq_addr(r.step + 3'h1, r.save);
          next_r.st = nvc_pkg::ST_SETUP;
        end else begin
          next_r.st = nvc_pkg::ST_IDLE;
          next_r.done = 1'b1;
          next_r.ready = 1'b1;
        end
      end
      nvc_pkg::ST_BUSY: begin
        // Erase/program or clear/copy happens inside the device
        if (r.cnt >= (r.save ? SAVE_T : RESTORE_T) - 20'h1) begin
          next_r.cnt = '0;
          next_r.st = nvc_pkg::ST_IDLE;
          next_r.seq = 1'b0;
          next_r.done = 1'b1;
          next_r.ready = 1'b1;
        end else begin
          next_r.cnt = r.cnt + 20'h1;
        end
      end
      default: begin
        next_r.st = nvc_pkg::ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      r <= '0;
      r.st <= nvc_pkg::ST_POWERUP;
      r.pins.select_n <= 1'b1;
      r.pins.write_n <= 1'b1;
      r.pins.gate_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign REQ_READY = r.ready;
  assign RSP_VALID = r.done;
  assign RSP_RDATA = r.rdata;
  assign NV_SELECT_N = r.pins.select_n;
  assign NV_WRITE_N = r.pins.write_n;
  assign NV_GATE_N = r.pins.gate_n;
  assign ADDR_LINES = r.pins.addr;
  assign DATA_LINES_O = r.pins.dout;
  assign DATA_LINES_OE = r.pins.drive;
endmodule

// ===== dv/nvc_host_chk.sv
// Bus protocol checker for the nonvolatile SRAM host controller
module nvc_host_chk (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic REQ_VALID,
  input wire logic [1:0] REQ_CMD,
  input wire logic REQ_READY,
  input wire logic RSP_VALID,
  input wire logic NV_SELECT_N,
  input wire logic NV_WRITE_N,
  input wire logic NV_GATE_N,
  input wire logic [12:0] ADDR_LINES,
  input wire logic DATA_LINES_OE
);
  logic nv;
  wire take = REQ_VALID && REQ_READY;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  // High from a save or restore request until its answer
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) nv <= 1'b0;
    else if (take) nv <= REQ_CMD[1];
    else if (RSP_VALID) nv <= 1'b0;
  end
  property p_pulse;
    $fell(NV_SELECT_N) |-> !NV_SELECT_N [*3] ##1 NV_SELECT_N;
  endproperty
  a_pulse: assert property (p_pulse) else $error("select pulse");
  property p_wr;
    !NV_WRITE_N |-> NV_GATE_N && !NV_SELECT_N;
  endproperty
  a_wr: assert property (p_wr) else $error("write gate");
  property p_addr;
    !NV_SELECT_N |=> $stable(ADDR_LINES) || NV_SELECT_N;
  endproperty
  a_addr: assert property (p_addr) else $error("address moved");
  property p_seq_w;
    nv |-> NV_WRITE_N;
  endproperty
  a_seq_w: assert property (p_seq_w) else $error("write in seq");
  property p_rd_g;
    !NV_SELECT_N && NV_WRITE_N |-> !NV_GATE_N;
  endproperty
  a_rd_g: assert property (p_rd_g) else $error("read gate");
  property p_lat;
    take && !REQ_CMD[1] |-> ##6 RSP_VALID;
  endproperty
  a_lat: assert property (p_lat) else $error("access latency");
  property p_nv_len;
    take && REQ_CMD[1] |=> !RSP_VALID [*8] ##[22:1000] RSP_VALID;
  endproperty
  a_nv_len: assert property (p_nv_len) else $error("nv length");
  property p_busy;
    nv && !RSP_VALID |-> !REQ_READY;
  endproperty
  a_busy: assert property (p_busy) else $error("ready in nv");
  property p_oe;
    !NV_WRITE_N |-> DATA_LINES_OE && NV_GATE_N;
  endproperty
  a_oe: assert property (p_oe) else $error("write drive");
  property p_nv_oe;
    nv |-> !DATA_LINES_OE;
  endproperty
  a_nv_oe: assert property (p_nv_oe) else $error("drive in nv");
endmodule

bind nvc_host nvc_host_chk nvc_host_chk_inst (.*);

// ===== dv/nv_sram_model.sv
// Behavioural model of the 8K x 8 SRAM with shadow array
module nv_sram_model #(
  parameter int SAVE_NS = 800,
  parameter int RCL_NS = 300
) (
  input wire logic select_n,
  input wire logic write_n,
  input wire logic gate_n,
  input wire logic [12:0] addr,
  input wire logic [7:0] din,
  output logic [7:0] dout
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sram [8192];
  logic [7:0] shadow [8192];
  logic [12:0] seq [5] = '{13'h0, 13'h1555, 13'h0aaa, 13'h1fff, 13'h10f0};
  logic busy = 1'b1;
  logic [1:0] acc = 2'h0;
  int step = 0;
  // Blocks the access process, so all inputs are ignored meanwhile
  task automatic run(input logic save);
    busy = 1'b1;
    if (save) shadow = sram;
    else sram = shadow;
    #(save ? SAVE_NS : RCL_NS); // Supply never sags, save not cut
    busy = 1'b0;
  endtask
  initial begin
    for (int i = 0; i < 8192; i++) shadow[i] = i[7:0] ^ 8'h5a;
    run(1'b0);
  end
  always @(negedge select_n or negedge write_n) begin
    if (!busy && !select_n) acc = write_n ? 2'h1 : 2'h2;
  end
  always @(posedge select_n or posedge write_n) begin
    if (acc == 2'h2) begin
      sram[addr] = din;
      step = 0;
    end else if (acc == 2'h1 && step == 5 && addr[12:1] == 12'h787) begin
      run(addr[0]);
      step = 0;
    end else if (acc == 2'h1)
      step = (step < 5 && addr == seq[step]) ? step + 1 : int'(addr == 0);
    acc = 2'h0;
  end
  // Undriven lines show the inverted stored byte, never the stored byte
  assign dout = (!select_n && !gate_n && write_n && !busy) ?
    sram[addr] : ~sram[addr];
endmodule

// ===== dv/tb_nvc_host.sv
// Self-checking bench for the nonvolatile SRAM host controller
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin \
  mismatches++; $display("Error %0t: %h not %h", $time, g, e); end end
module tb_nvc_host;
  timeunit 1ns;
  timeprecision 1ps;
  logic SYS_CLK = 0, RESET_N = 0, REQ_VALID = 0, REQ_READY, RSP_VALID;
  logic NV_SELECT_N, NV_WRITE_N, NV_GATE_N, DATA_LINES_OE;
  logic [1:0] REQ_CMD = 0;
  logic [12:0] REQ_ADDR = 0, ADDR_LINES;
  logic [7:0] REQ_WDATA = 0, RSP_RDATA, DATA_LINES_O, DATA_LINES_I;
  int mismatches = 0, checked = 0;
  nvc_host #(.SAVE_CYCLES(50), .RESTORE_CYCLES(20), .POWERUP_CYCLES(20))
    nvc_host_inst (.*);
  nv_sram_model nv_sram_model_inst (.select_n(NV_SELECT_N),
    .write_n(NV_WRITE_N), .gate_n(NV_GATE_N), .addr(ADDR_LINES),
    .din(DATA_LINES_OE ? DATA_LINES_O : ~DATA_LINES_O), .dout(DATA_LINES_I));
  task test_done;
    if (mismatches == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wait_hi(ref logic s);
    for (int i = 0; s !== 1'b1; i++) begin
      if (i == 4000) begin
        mismatches++;
        test_done;
      end
      @(posedge SYS_CLK);
      #1;
    end
  endtask
  task op(input logic [1:0] c, input logic [12:0] a, input logic [7:0] d);
    wait_hi(REQ_READY);
    REQ_CMD = c;
    REQ_ADDR = a;
    REQ_WDATA = d;
    REQ_VALID = 1;
    @(posedge SYS_CLK);
    #1;
    REQ_VALID = 0;
    wait_hi(RSP_VALID);
  endtask
  task rd(input logic [12:0] a, input logic [7:0] e);
    op(nvc_pkg::CMD_READ, a, 8'h00);
    `CHK(RSP_RDATA, e)
  endtask
  task rs(input logic [12:0] q[$]);
    foreach (q[i]) op(nvc_pkg::CMD_READ, q[i], 8'h00);
  endtask
  task t_rw;
    rd(13'h0123, 8'h23 ^ 8'h5a);
    op(nvc_pkg::CMD_WRITE, 13'h1fff, 8'ha5);
    op(nvc_pkg::CMD_WRITE, 13'h0000, 8'h3c);
    rd(13'h1fff, 8'ha5);
    rd(13'h0000, 8'h3c);
  endtask
  task t_nv;
    op(nvc_pkg::CMD_WRITE, 13'h0055, 8'h11);
    op(nvc_pkg::CMD_SAVE, 13'h0, 8'h00);
    op(nvc_pkg::CMD_WRITE, 13'h0055, 8'h22);
    rd(13'h0055, 8'h22);
    op(nvc_pkg::CMD_RESTORE, 13'h0, 8'h00);
    rd(13'h0055, 8'h11);
  endtask
  task t_abort;
    op(nvc_pkg::CMD_WRITE, 13'h0055, 8'h33);
    rs('{13'h0, 13'h1555, 13'h0aaa});
    op(nvc_pkg::CMD_WRITE, 13'h0777, 8'h00);
    rs('{13'h1fff, 13'h10f0, 13'h0f0e});
    rd(13'h0055, 8'h33);
    rs('{13'h0, 13'h1555, 13'h1555, 13'h0aaa, 13'h1fff, 13'h10f0});
    rs('{13'h0f0e});
    rd(13'h0055, 8'h33);
    rs('{13'h0, 13'h1555, 13'h0, 13'h1555, 13'h0aaa, 13'h1fff});
    rs('{13'h10f0, 13'h0f0e});
    repeat (20) @(posedge SYS_CLK);
    #1;
    rd(13'h0055, 8'h11);
  endtask
  initial begin
    forever #10 SYS_CLK = ~SYS_CLK;
  end
  initial begin
    repeat (4) @(posedge SYS_CLK);
    #1;
    RESET_N = 1;
    t_rw;
    t_nv;
    t_abort;
    test_done;
  end
endmodule
